/* File: serial_switch_spi_control.sv */
// spi slave front end of the sixteen output switch
`timescale 1ns/1ns
module serial_switch_spi_control #(
   parameter int FILTER_CYCLES = switch_spi_pkg::FILTER_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        reset_n,
   input  wire logic        supply_ok,
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        mosi,
   output logic             miso_o,
   output logic             miso_oe,
   input  wire logic [15:0] short_fault_raw,
   input  wire logic [15:0] open_fault_raw,
   input  wire logic        overvoltage,
   output logic [23:0]      command_word,
   output logic             command_strobe,
   input  wire logic        command_ready
);
   localparam int FB = switch_spi_pkg::FRAME_BITS;
   localparam int CH = switch_spi_pkg::CHANNELS;
   localparam int CW = $clog2(FILTER_CYCLES + 1);

   // synchroniser stages
   logic [1:0] cs_s_r;
   logic [1:0] sck_s_r;
   logic [1:0] si_s_r;
   logic [1:0] rn_s_r;
   logic [1:0] sup_s_r;
   logic       cs_d_r;
   logic       sck_d_r;
   logic       hold_rst;
   logic       cs_fall;
   logic       cs_rise;
   logic       sck_rise;
   logic       sck_fall;
   logic [FB-1:0] shift_r;
   logic          so_bit_r;
   logic          oe_r;
   logic [CH-1:0] fault_r;
   logic          ov_r;
   logic [FB-1:0] status;
   logic [FB-1:0] fifo_data;
   logic          fifo_valid;
   logic          fifo_in_ready;
   logic [FB-1:0] latch_r;
   logic          strobe_r;

   // two flops on every pin input
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cs_s_r  <= 2'h3;
         sck_s_r <= 2'h0;
         si_s_r  <= 2'h0;
         rn_s_r  <= 2'h0;
         sup_s_r <= 2'h0;
      end
      else
      begin
         cs_s_r  <= {cs_s_r[0], cs_n};
         sck_s_r <= {sck_s_r[0], sclk};
         si_s_r  <= {si_s_r[0], mosi};
         rn_s_r  <= {rn_s_r[0], reset_n};
         sup_s_r <= {sup_s_r[0], supply_ok};
      end
   end

   // reset pin and supply monitor hold all logic
   assign hold_rst = rst || !rn_s_r[1] || !sup_s_r[1];

   // edge history
   always_ff @(posedge clk)
   begin
      if (hold_rst)
      begin
         cs_d_r  <= 1'b1;
         sck_d_r <= 1'b0;
      end
      else
      begin
         cs_d_r  <= cs_s_r[1];
         sck_d_r <= sck_s_r[1];
      end
   end

   assign cs_fall  = cs_d_r && !cs_s_r[1];
   assign cs_rise  = !cs_d_r && cs_s_r[1];
   // clock edges count only while selected
   assign sck_rise = !cs_s_r[1] && !cs_d_r && !sck_d_r && sck_s_r[1];
   assign sck_fall = !cs_s_r[1] && !cs_d_r && sck_d_r && !sck_s_r[1];

   // status word layout, bits 21..16 zero
   assign status = {ov_r | (|fault_r), ov_r, 6'h00, fault_r};

   // one shared chain: sample and shift on fall, drive out on rise
   always_ff @(posedge clk)
   begin
      if (hold_rst)
      begin
         shift_r  <= '0;
         so_bit_r <= 1'b0;
      end
      else if (cs_fall)
      begin
         shift_r  <= status;
         so_bit_r <= status[FB-1];
      end
      else if (sck_fall)
      begin
         shift_r <= {shift_r[FB-2:0], si_s_r[1]};
      end
      else if (sck_rise)
      begin
         so_bit_r <= shift_r[FB-1];
      end
   end

   // output enable follows select
   always_ff @(posedge clk)
   begin
      if (hold_rst)
      begin
         oe_r <= 1'b0;
      end
      else
      begin
         oe_r <= !cs_s_r[1];
      end
   end

   assign miso_oe = oe_r;
   assign miso_o  = oe_r ? so_bit_r : 1'b0;

   // per channel fault filters, restarted by each commit
   genvar g;
   generate
      for (g = 0; g < CH; g++)
      begin : g_filt
         logic [CW-1:0] cnt_r;
         logic          raw;
         assign raw = short_fault_raw[g] | open_fault_raw[g];
         always_ff @(posedge clk)
         begin
            if (hold_rst)
            begin
               cnt_r      <= '0;
               fault_r[g] <= 1'b0;
            end
            else
            begin
               if (cs_rise || !raw)
               begin
                  cnt_r <= '0;
               end
               else if (cnt_r != CW'(FILTER_CYCLES))
               begin
                  cnt_r <= CW'(cnt_r + 1'b1);
               end
               if (cs_fall)
               begin
                  fault_r[g] <= raw && (cnt_r == CW'(FILTER_CYCLES));
               end
               else if (raw && (cnt_r == CW'(FILTER_CYCLES)))
               begin
                  fault_r[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // overvoltage flag latched until next status load
   always_ff @(posedge clk)
   begin
      if (hold_rst)
      begin
         ov_r <= 1'b0;
      end
      else if (overvoltage)
      begin
         ov_r <= 1'b1;
      end
      else if (cs_fall)
      begin
         ov_r <= 1'b0;
      end
   end

   // committed words queue before the output latches
   cmd_fifo #(
      .WIDTH (FB),
      .DEPTH (switch_spi_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (hold_rst),
      .in_data   (shift_r),
      .in_valid  (cs_rise),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (command_ready)
   );

   // output latches, all off in reset
   always_ff @(posedge clk)
   begin
      if (hold_rst)
      begin
         latch_r  <= switch_spi_pkg::CMD_RESET;
         strobe_r <= 1'b0;
      end
      else
      begin
         strobe_r <= fifo_valid && command_ready;
         if (fifo_valid && command_ready)
         begin
            latch_r <= fifo_data;
         end
      end
   end

   assign command_word   = latch_r;
   assign command_strobe = strobe_r;
endmodule // serial_switch_spi_control

/* File: switch_spi_pkg.sv */
// constants shared by the serial switch control logic
package switch_spi_pkg;
   localparam int FRAME_BITS   = 24;
   localparam int CHANNELS     = 16;
   localparam int BIT_ANY      = 23;
   localparam int BIT_OV       = 22;
   localparam int CLK_HZ       = 20000000;
   localparam int FILTER_US    = 100;
   localparam int FILTER_CYC   = (FILTER_US * (CLK_HZ / 1000000));
   localparam int FIFO_DEPTH   = 4;
   localparam logic [23:0] CMD_RESET = 24'h000000;
endpackage

/* File: cmd_fifo.sv */
// small flop fifo for committed command words
`timescale 1ns/1ns
module cmd_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   // handshakes from the fill count
   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_r[rd_r];

   // storage
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_r[wr_r] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : AW'(wr_r + 1'b1);
         end
         if (pop)
         begin
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : AW'(rd_r + 1'b1);
         end
         if (push && !pop)
         begin
            cnt_r <= (AW+1)'(cnt_r + 1'b1);
         end
         else if (pop && !push)
         begin
            cnt_r <= (AW+1)'(cnt_r - 1'b1);
         end
      end
   end
endmodule // cmd_fifo

/* File: spi_ctl_sva.sv */
// port assertions for the serial switch control block
`timescale 1ns/1ns
module spi_ctl_sva (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        reset_n,
   input wire logic        supply_ok,
   input wire logic        cs_n,
   input wire logic        miso_o,
   input wire logic        miso_oe,
   input wire logic [23:0] command_word,
   input wire logic        command_strobe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst || !reset_n || !supply_ok);
   // serial output enable and idle level
   a_oe_lag: assert property (miso_oe == !$past(cs_n, 3))
      else $error("oe lag");
   a_miso_idle: assert property (!miso_oe |-> !miso_o)
      else $error("miso idle");
   // latch update and strobe
   a_strobe_after: assert property ($changed(command_word) |-> command_strobe)
      else $error("no strobe");
   // pin reset and supply hold everything off
   a_rst_word_off: assert property (disable iff (rst) !reset_n [*4] |-> command_word == 0)
      else $error("word in reset");
   a_rst_oe_off: assert property (disable iff (rst) !reset_n [*4] |-> !miso_oe)
      else $error("oe in reset");
   a_supply_off: assert property (disable iff (rst) !supply_ok [*4] |-> command_word == 0)
      else $error("word low supply");
   a_supply_oe_off: assert property (disable iff (rst) !supply_ok [*4] |-> !miso_oe)
      else $error("oe low supply");
   a_sync_clear: assert property (disable iff (1'b0) rst |=> command_word == 0 && !miso_oe)
      else $error("sync reset");
   c_commit: cover property ($rose(command_strobe));
   c_select: cover property ($rose(miso_oe));
   c_pin_rst: cover property (!reset_n [*4]);
endmodule // spi_ctl_sva
bind serial_switch_spi_control spi_ctl_sva spi_ctl_sva_inst (.clk, .rst, .reset_n,
   .supply_ok, .cs_n, .miso_o, .miso_oe, .command_word, .command_strobe);

/* File: spi_host.sv */
// spi master model standing in for the host controller
`timescale 1ns/1ns
module spi_host (
   input wire logic clk,
   input wire logic miso_o,
   input wire logic miso_oe,
   output logic     cs_n,
   output logic     sclk,
   output logic     mosi
);
   logic so;
   // released data line is pulled up, seen as inverse of idle low
   assign so = miso_oe ? miso_o : 1'b1;
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // one frame of nbits, msb first both ways; mosi moves mid high phase
   task automatic xfer(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
      rx = 48'h0;
      @(posedge clk) cs_n <= 1'b0;
      repeat (6) @(posedge clk);
      for (int i = nbits - 1; i >= 0; i--)
      begin
         @(posedge clk) sclk <= 1'b1;
         repeat (2) @(posedge clk);
         mosi <= tx[i];
         @(posedge clk);
         // take the bit the rise has put out, just before the fall
         @(negedge clk) rx = {rx[46:0], so};
         @(posedge clk) sclk <= 1'b0;
         repeat (3) @(posedge clk);
      end
      cs_n <= 1'b1;
      mosi <= 1'b0;
      repeat (16) @(posedge clk);
   endtask
endmodule // spi_host

/* File: tb_top.sv */
// self-checking bench for the serial switch control block
`timescale 1ns/1ns
module tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        reset_n = 1'b1;
   logic        supply_ok = 1'b1;
   logic        overvoltage = 1'b0;
   logic        command_ready = 1'b1;
   logic [15:0] short_fault_raw = 16'h0000;
   logic [15:0] open_fault_raw = 16'h0000;
   logic        cs_n, sclk, mosi, miso_o, miso_oe, command_strobe;
   logic [23:0] command_word;
   logic [47:0] rx;
   int          fails = 0;
   int          n_compared = 0;
   always #25 clk = ~clk;
   serial_switch_spi_control #(.FILTER_CYCLES(8)) serial_switch_spi_control_inst (.clk, .rst,
      .reset_n, .supply_ok, .cs_n, .sclk, .mosi, .miso_o, .miso_oe, .short_fault_raw,
      .open_fault_raw, .overvoltage, .command_word, .command_strobe, .command_ready);
   spi_host spi_host_inst (.clk, .miso_o, .miso_oe, .cs_n, .sclk, .mosi);
   task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("mismatches %0d of %0d compared", fails, n_compared);
      if (fails == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // frames, faults, fifo backlog, reset pins
   initial
   begin
      wt(20);
      rst <= 1'b0;
      wt(4);
      spi_host_inst.xfer(48'h5a3c81, 24, rx);
      @(negedge clk);
      chk("clean status", rx, 48'h0);
      chk("word", {24'h0, command_word}, 48'h5a3c81);
      @(posedge clk);
      short_fault_raw <= 16'h8001;
      open_fault_raw <= 16'h0100;
      overvoltage <= 1'b1;
      wt(20);
      spi_host_inst.xfer({24'hc3a5f0, 24'h123456}, 48, rx);
      @(negedge clk);
      chk("status", {24'h0, rx[47:24]}, 48'hc08101);
      chk("echo", {24'h0, rx[23:0]}, 48'hc3a5f0);
      chk("chain word", {24'h0, command_word}, 48'h123456);
      @(posedge clk);
      short_fault_raw <= 16'h0000;
      open_fault_raw <= 16'h0000;
      overvoltage <= 1'b0;
      command_ready <= 1'b0;
      for (int k = 1; k <= 5; k++)
         spi_host_inst.xfer(48'h100000 + k, 24, rx);
      @(negedge clk);
      chk("held word", {24'h0, command_word}, 48'h123456);
      @(posedge clk);
      command_ready <= 1'b1;
      wt(20);
      @(negedge clk);
      chk("drained word", {24'h0, command_word}, 48'h100004);
      for (int j = 0; j < 2; j++)
      begin
         spi_host_inst.xfer(48'h00ff00, 24, rx);
         reset_n <= (j != 0);
         supply_ok <= (j == 0);
         wt(8);
         @(negedge clk);
         chk("word in reset", {24'h0, command_word}, 48'h0);
         @(posedge clk);
         reset_n <= 1'b1;
         supply_ok <= 1'b1;
         wt(8);
      end
      end_sim;
   end
   // watchdog
   initial
   begin
      wt(20000);
      fails++;
      end_sim;
   end
endmodule // tb_top
